// file: common/tgr_pkg.sv
// Package with register map, field positions and shared types for the timer gate.
package tgr_pkg;

    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [7:0] TIMER_CONTROL_OFS = 8'h00;
    localparam logic [7:0] GATE_CONTROL_OFS = 8'h04;
    localparam logic [7:0] COUNT_OFS = 8'h08;
    localparam logic [7:0] CAPTURE_COMPARE_OFS = 8'h0C;
    localparam logic [7:0] IRQ_CONTROL_OFS = 8'h10;
    localparam logic [7:0] PERIPHERAL_ENABLE_OFS = 8'h14;
    localparam logic [7:0] PERIPHERAL_FLAG_OFS = 8'h18;
    localparam logic [7:0] WATCHDOG_CONFIG_OFS = 8'h1C;

    // Timer control fields.
    localparam int TC_RUN = 0;
    localparam int TC_SYNC_BYPASS = 2;
    localparam int TC_CCU_MODE = 8;

    // Gate control fields.
    localparam int GC_SRC_LO = 0;
    localparam int GC_LEVEL = 2;
    localparam int GC_ARMED = 3;
    localparam int GC_SPM = 4;
    localparam int GC_TOGGLE = 5;
    localparam int GC_POL = 6;
    localparam int GC_ENABLE = 7;

    // Interrupt control fields.
    localparam int IC_PERIPH = 6;
    localparam int IC_GLOBAL = 7;

    // Peripheral enable and flag fields.
    localparam int PF_ROLLOVER = 0;
    localparam int PF_GATE = 7;

    // Watchdog configuration fields.
    localparam int WC_ENABLE = 0;
    localparam int WC_PSA = 3;
    localparam int WC_RATE_LO = 0;

    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [15:0] IRQ_VECTOR = 16'h0004;

    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        TGR_SRC_PIN = 2'b00,
        TGR_SRC_T8_OVF = 2'b01,
        TGR_SRC_PERIOD = 2'b10,
        TGR_SRC_WDOG = 2'b11
    } tgr_src_t;

    typedef enum logic [1:0] {
        TGR_CCU_OFF = 2'b00,
        TGR_CCU_CAPTURE = 2'b01,
        TGR_CCU_COMPARE = 2'b10
    } tgr_ccu_t;

    // Gate source inputs travel together.
    typedef struct packed {
        logic gate_input;
        logic t8_overflow;
        logic period_match;
        logic wdog_overflow;
    } tgr_sources_t;

    // Watchdog control outputs travel together.
    typedef struct packed {
        logic osc_on;
        logic reset_en;
        logic wake_en;
        logic prescaler_assign;
        logic [2:0] prescaler_rate;
    } tgr_wdog_t;

endpackage

// file: verilog/tgr_timer_gate.sv
// Gate control, rollover and capture/compare time base of a 16-bit timer.
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// - Watchdog runs when gated by source 11.
// - Watchdog interval still set by prescaler bits.
// - Gate use never enables watchdog reset/wake.
// - Toggle flop flips on each active gate edge.
// - Toggle flop held clear while toggle off.
// - Armed single pulse counts from next edge.
// - Armed cleared on trailing edge; others ignored.
// - Clearing single-pulse enable clears armed.
// - Toggle plus single pulse opens the gate for one clk cycle.
// - Gate level status readable, always valid.
// - Level falling edge sets gate event flag.
// - Gate event flag works with gate disabled.
// - Count wraps FFFF to 0000, sets rollover.
// - Rollover irq needs run and three enables.
// - Rollover flag sticks until software clears.
// - Sleep counting only asynchronous, wakes on rollover.
// - Wake continues, or vectors when global enabled.
// - Counter mode needs falling edge before rising.
// - Count is capture/compare time base.
// - Source select: pin, overflow, match, watchdog.
// - Gated count increments only while gate active.
module tgr_timer_gate
(
    input wire logic clk, // 125 MHz clock
    input wire logic reset, // Synchronous reset, active high
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic timer_clk, // Selected timer clock, sampled
    input wire tgr_pkg::tgr_sources_t sources, // Gate sources
    input wire logic ccu_capture_event, // Capture trigger pulse
    input wire logic sleeping, // Core is asleep
    output tgr_pkg::tgr_wdog_t wdog, // Watchdog controls
    output logic irq, // Interrupt request level
    output logic wake, // Wake request pulse
    output logic [15:0] wake_vector, // Vector on wake, zero = next
    output logic compare_event // Compare match pulse
);

    logic [8:0] timer_control_q;
    logic [7:0] gate_control_q;
    logic [15:0] count_q;
    logic [15:0] ccr_q;
    logic [7:0] irq_control_q;
    logic [7:0] periph_enable_q;
    logic rollover_flag_q;
    logic gate_event_flag_q;
    logic [7:0] wdog_config_q;
    logic toggle_q;
    logic level_q;
    logic src_q;
    logic clk_q;
    logic fell_seen_q;
    logic pulse_started_q;
    logic [7:0] aw_addr_q;
    logic aw_have_q;
    logic [31:0] w_data_q;
    logic w_have_q;
    logic [3:0] s_axi_wstrb_q;

    function automatic logic w_strb_ok(input logic [3:0] strb);
        w_strb_ok = strb[0];
    endfunction

    logic timer_run;
    logic sync_bypass;
    logic gate_count_enable;
    logic gate_polarity;
    logic gate_toggle_enable;
    logic gate_single_pulse_enable;
    logic gate_pulse_armed;
    tgr_pkg::tgr_src_t gate_source_select;
    tgr_pkg::tgr_ccu_t ccu_mode;
    logic src_sel;
    logic src_rise;
    logic gate_value;
    logic level_fall;
    logic clk_rise;
    logic count_tick;
    logic wrap;
    logic do_write;
    logic wr_count;
    logic wr_gate;
    logic wr_flag;
    logic wr_ccr;
    logic sleep_ok;

    assign timer_run = timer_control_q[tgr_pkg::TC_RUN];
    assign sync_bypass = timer_control_q[tgr_pkg::TC_SYNC_BYPASS];
    assign ccu_mode = tgr_pkg::tgr_ccu_t'(
        timer_control_q[tgr_pkg::TC_CCU_MODE -: 2]);
    assign gate_count_enable = gate_control_q[tgr_pkg::GC_ENABLE];
    assign gate_polarity = gate_control_q[tgr_pkg::GC_POL];
    assign gate_toggle_enable = gate_control_q[tgr_pkg::GC_TOGGLE];
    assign gate_single_pulse_enable = gate_control_q[tgr_pkg::GC_SPM];
    assign gate_pulse_armed = gate_control_q[tgr_pkg::GC_ARMED];
    assign gate_source_select = tgr_pkg::tgr_src_t'(
        gate_control_q[tgr_pkg::GC_SRC_LO +: 2]);

    always_comb
    begin
        case (gate_source_select)
            tgr_pkg::TGR_SRC_PIN: src_sel = sources.gate_input;
            tgr_pkg::TGR_SRC_T8_OVF: src_sel = sources.t8_overflow;
            tgr_pkg::TGR_SRC_PERIOD: src_sel = sources.period_match;
            tgr_pkg::TGR_SRC_WDOG: src_sel = sources.wdog_overflow;
            default: src_sel = 1'b0;
        endcase
    end

    // Polarity applied before the toggle flop so it flips on active edges.
    assign src_rise = (src_sel ^ ~gate_polarity) & ~src_q;

    // Gate value: toggle output or level, then the single-pulse window.
    always_comb
    begin
        gate_value = gate_toggle_enable ? toggle_q
            : (src_sel ^ ~gate_polarity);
        if (gate_single_pulse_enable)
        begin
            gate_value = gate_value & gate_pulse_armed
                & (pulse_started_q | src_rise);
        end
    end

    assign level_fall = level_q & ~gate_value;
    assign clk_rise = timer_clk & ~clk_q & fell_seen_q;
    assign sleep_ok = ~sleeping | sync_bypass;
    assign count_tick = timer_run & clk_rise & sleep_ok
        & (~gate_count_enable | gate_value);
    assign wrap = count_tick & (count_q == tgr_pkg::COUNT_MAX);

    // Bus write decode.
    assign do_write = aw_have_q & w_have_q & ~s_axi_bvalid;
    assign wr_count = do_write & (aw_addr_q == tgr_pkg::COUNT_OFS);
    assign wr_gate = do_write & (aw_addr_q == tgr_pkg::GATE_CONTROL_OFS);
    assign wr_flag = do_write & (aw_addr_q == tgr_pkg::PERIPHERAL_FLAG_OFS);
    assign wr_ccr = do_write & (aw_addr_q == tgr_pkg::CAPTURE_COMPARE_OFS);

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_have_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= tgr_pkg::AXI_OKAY;
        end
        else
        begin
            s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready)
            begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready)
            begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
            end
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_q[1:0] == 2'b00
                    && aw_addr_q <= tgr_pkg::WATCHDOG_CONFIG_OFS)
                    ? tgr_pkg::AXI_OKAY : tgr_pkg::AXI_SLVERR;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
            end
            else if (s_axi_bvalid & s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Plain configuration registers.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            timer_control_q <= 9'h000;
            irq_control_q <= 8'h00;
            periph_enable_q <= 8'h00;
            wdog_config_q <= 8'h00;
        end
        else if (do_write & w_strb_ok(s_axi_wstrb_q))
        begin
            case (aw_addr_q)
                tgr_pkg::TIMER_CONTROL_OFS:
                    timer_control_q <= w_data_q[8:0];
                tgr_pkg::IRQ_CONTROL_OFS:
                    irq_control_q <= w_data_q[7:0];
                tgr_pkg::PERIPHERAL_ENABLE_OFS:
                    periph_enable_q <= w_data_q[7:0];
                tgr_pkg::WATCHDOG_CONFIG_OFS:
                    wdog_config_q <= w_data_q[7:0];
                default:
                    ;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            s_axi_wstrb_q <= 4'h0;
        else if (s_axi_wvalid & s_axi_wready)
            s_axi_wstrb_q <= s_axi_wstrb;
    end

    // Gate control register; level bit is read-only.
    always_ff @(posedge clk)
    begin
        if (reset)
            gate_control_q <= 8'h00;
        else
        begin
            if (wr_gate & w_strb_ok(s_axi_wstrb_q))
            begin
                gate_control_q <= w_data_q[7:0];
                gate_control_q[tgr_pkg::GC_LEVEL] <= level_q;
                if (!w_data_q[tgr_pkg::GC_SPM])
                    gate_control_q[tgr_pkg::GC_ARMED] <= 1'b0;
            end
            else if (gate_single_pulse_enable & gate_pulse_armed
                & pulse_started_q & level_fall)
            begin
                gate_control_q[tgr_pkg::GC_ARMED] <= 1'b0;
            end
            if (!(wr_gate & w_strb_ok(s_axi_wstrb_q)))
                gate_control_q[tgr_pkg::GC_LEVEL] <= gate_value;
        end
    end

    // Toggle flop, single-pulse start marker and edge history.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            toggle_q <= 1'b0;
            src_q <= 1'b0;
            level_q <= 1'b0;
            pulse_started_q <= 1'b0;
        end
        else
        begin
            src_q <= src_sel ^ ~gate_polarity;
            level_q <= gate_value;
            if (!gate_toggle_enable)
                toggle_q <= 1'b0;
            else if (src_rise)
                toggle_q <= ~toggle_q;
            if (!(gate_single_pulse_enable & gate_pulse_armed))
                pulse_started_q <= 1'b0;
            else if (gate_value)
                pulse_started_q <= 1'b1;
        end
    end

    // Counter-mode edge qualification.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            clk_q <= 1'b1;
            fell_seen_q <= 1'b0;
        end
        else
        begin
            clk_q <= timer_clk;
            if (!timer_run | wr_count)
                fell_seen_q <= 1'b0;
            else if (!timer_clk & clk_q)
                fell_seen_q <= 1'b1;
        end
    end

    // Count pair and capture/compare pair.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            count_q <= tgr_pkg::COUNT_ZERO;
            ccr_q <= tgr_pkg::COUNT_ZERO;
            compare_event <= 1'b0;
        end
        else
        begin
            if (wr_count)
                count_q <= w_data_q[15:0];
            else if (count_tick)
                count_q <= count_q + 16'h0001;
            if (wr_ccr)
                ccr_q <= w_data_q[15:0];
            else if (ccu_mode == tgr_pkg::TGR_CCU_CAPTURE & ccu_capture_event)
                ccr_q <= count_q;
            compare_event <= (ccu_mode == tgr_pkg::TGR_CCU_COMPARE)
                & count_tick & (count_q + 16'h0001 == ccr_q);
        end
    end

    // Sticky flags: a hardware set wins over a software clear.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rollover_flag_q <= 1'b0;
            gate_event_flag_q <= 1'b0;
        end
        else
        begin
            if (wrap)
                rollover_flag_q <= 1'b1;
            else if (wr_flag & ~w_data_q[tgr_pkg::PF_ROLLOVER])
                rollover_flag_q <= 1'b0;
            if (level_fall)
                gate_event_flag_q <= 1'b1;
            else if (wr_flag & ~w_data_q[tgr_pkg::PF_GATE])
                gate_event_flag_q <= 1'b0;
        end
    end

    logic periph_on;
    logic roll_pend;
    logic gate_pend;
    assign periph_on = irq_control_q[tgr_pkg::IC_PERIPH];
    assign roll_pend = rollover_flag_q & timer_run
        & periph_enable_q[tgr_pkg::PF_ROLLOVER] & periph_on;
    assign gate_pend = gate_event_flag_q
        & periph_enable_q[tgr_pkg::PF_GATE] & periph_on;

    // Interrupt, wake and watchdog outputs.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            irq <= 1'b0;
            wake <= 1'b0;
            wake_vector <= tgr_pkg::COUNT_ZERO;
            wdog <= '0;
        end
        else
        begin
            irq <= (roll_pend | gate_pend)
                & irq_control_q[tgr_pkg::IC_GLOBAL];
            wake <= sleeping & wrap & sync_bypass
                & periph_enable_q[tgr_pkg::PF_ROLLOVER] & periph_on;
            if (sleeping & wrap)
                wake_vector <= irq_control_q[tgr_pkg::IC_GLOBAL]
                    ? tgr_pkg::IRQ_VECTOR : tgr_pkg::COUNT_ZERO;
            wdog.osc_on <= wdog_config_q[tgr_pkg::WC_ENABLE]
                | (gate_count_enable
                & gate_source_select == tgr_pkg::TGR_SRC_WDOG);
            wdog.reset_en <= wdog_config_q[tgr_pkg::WC_ENABLE];
            wdog.wake_en <= wdog_config_q[tgr_pkg::WC_ENABLE];
            wdog.prescaler_assign <= wdog_config_q[tgr_pkg::WC_PSA];
            wdog.prescaler_rate <=
                wdog_config_q[tgr_pkg::WC_RATE_LO +: 3];
        end
    end

    // Read channel.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= tgr_pkg::AXI_OKAY;
        end
        else
        begin
            s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
            if (s_axi_arvalid & s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= tgr_pkg::AXI_OKAY;
                s_axi_rdata <= 32'h0000_0000;
                case (s_axi_araddr)
                    tgr_pkg::TIMER_CONTROL_OFS:
                        s_axi_rdata[8:0] <= timer_control_q;
                    tgr_pkg::GATE_CONTROL_OFS:
                        s_axi_rdata[7:0] <= gate_control_q;
                    tgr_pkg::COUNT_OFS:
                        s_axi_rdata[15:0] <= count_q;
                    tgr_pkg::CAPTURE_COMPARE_OFS:
                        s_axi_rdata[15:0] <= ccr_q;
                    tgr_pkg::IRQ_CONTROL_OFS:
                        s_axi_rdata[7:0] <= irq_control_q;
                    tgr_pkg::PERIPHERAL_ENABLE_OFS:
                        s_axi_rdata[7:0] <= periph_enable_q;
                    tgr_pkg::PERIPHERAL_FLAG_OFS:
                    begin
                        s_axi_rdata[tgr_pkg::PF_ROLLOVER] <= rollover_flag_q;
                        s_axi_rdata[tgr_pkg::PF_GATE] <= gate_event_flag_q;
                    end
                    tgr_pkg::WATCHDOG_CONFIG_OFS:
                        s_axi_rdata[7:0] <= wdog_config_q;
                    default:
                        s_axi_rresp <= tgr_pkg::AXI_SLVERR;
                endcase
            end
            else if (s_axi_rvalid & s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    a_toggle_held: assert property (@(posedge clk) disable iff (reset)
        !gate_toggle_enable |=> !toggle_q)
        else $error("Toggle flop not held clear.");
    a_spm_clear: assert property (@(posedge clk) disable iff (reset)
        $fell(gate_single_pulse_enable) |-> !gate_pulse_armed)
        else $error("Armed bit survived single-pulse disable.");
    a_roll_wrap: assert property (@(posedge clk) disable iff (reset)
        wrap |=> count_q == tgr_pkg::COUNT_ZERO && rollover_flag_q)
        else $error("Wrap did not zero count and set flag.");
    a_roll_sticky: assert property (@(posedge clk) disable iff (reset)
        rollover_flag_q && !wr_flag |=> rollover_flag_q)
        else $error("Rollover flag dropped by itself.");
    a_gate_fall: assert property (@(posedge clk) disable iff (reset)
        level_fall |=> gate_event_flag_q)
        else $error("Gate level fall did not set event flag.");
    a_irq_needs: assert property (@(posedge clk) disable iff (reset)
        irq |-> $past(irq_control_q[tgr_pkg::IC_GLOBAL]))
        else $error("Interrupt without global enable.");
    a_wdog_on: assert property (@(posedge clk) disable iff (reset)
        gate_count_enable && gate_source_select == tgr_pkg::TGR_SRC_WDOG
        |=> wdog.osc_on)
        else $error("Watchdog oscillator not started.");
    a_hold_gate: assert property (@(posedge clk) disable iff (reset)
        gate_count_enable && !gate_value && !wr_count
        |=> $stable(count_q))
        else $error("Count moved while gate inactive.");

    c_wrap: cover property (@(posedge clk) wrap);
    c_gate_event: cover property (@(posedge clk) level_fall);
    c_single_done: cover property (@(posedge clk)
        $fell(gate_pulse_armed) && gate_single_pulse_enable);

endmodule // tgr_timer_gate

// file: test/tgr_src_model.sv
// Far-side model: timer clock, gate sources and watchdog overflow.
`timescale 1ns/1ps
module tgr_src_model
(
    input wire logic clk, // System clock
    input wire logic reset, // Synchronous reset
    input wire logic clk_run, // Let the timer clock run
    input wire logic gate_lvl, // Level for the gate pin
    input wire tgr_pkg::tgr_wdog_t wdog, // Watchdog controls
    output logic timer_clk, // Timer clock
    output tgr_pkg::tgr_sources_t sources // Gate sources
);
    logic [4:0] div_q;
    always_ff @(posedge clk)
    begin
        if (reset)
            div_q <= 5'h00;
        else
            div_q <= div_q + 5'h01;
    end
    // The timer clock stands low while stopped, so a rise precedes the first fall.
    assign timer_clk = clk_run & div_q[1];
    assign sources = '{
        gate_input: gate_lvl,
        t8_overflow: div_q[3:0] == 4'h0,
        period_match: div_q[3:0] == 4'h8,
        wdog_overflow: wdog.osc_on & (div_q == 5'h1F)
    };
endmodule // tgr_src_model

// file: test/tgr_timer_gate_tb.sv
// Self-checking bench for the timer gate block.
`timescale 1ns/1ps
module tgr_timer_gate_tb;
    localparam logic [7:0] TC = tgr_pkg::TIMER_CONTROL_OFS;
    localparam logic [7:0] GC = tgr_pkg::GATE_CONTROL_OFS;
    localparam logic [7:0] FL = tgr_pkg::PERIPHERAL_FLAG_OFS;
    localparam logic [7:0] CN = tgr_pkg::COUNT_OFS;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rv, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, clk_run = 1'b0;
    logic gate_lvl = 1'b0, cap_ev = 1'b0, sleeping = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, timer_clk;
    logic irq, wake, cmp_ev;
    logic [1:0] bresp, rresp;
    logic [15:0] wake_vector;
    tgr_pkg::tgr_sources_t sources;
    tgr_pkg::tgr_wdog_t wdog;
    int mismatches = 0, total_checks = 0, cyc = 0;

    tgr_timer_gate u_dut
    (
        .clk(clk), .reset(reset), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .timer_clk(timer_clk), .sources(sources),
        .ccu_capture_event(cap_ev), .sleeping(sleeping), .wdog(wdog),
        .irq(irq), .wake(wake), .wake_vector(wake_vector),
        .compare_event(cmp_ev)
    );

    tgr_src_model u_src
    (
        .clk(clk), .reset(reset), .clk_run(clk_run), .gate_lvl(gate_lvl),
        .wdog(wdog), .timer_clk(timer_clk), .sources(sources)
    );

    always #4 clk = ~clk;

    task automatic final_report();
        if (mismatches == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            mismatches++;
            final_report();
        end
    end

    task automatic chk(input string nm, input logic [31:0] g, e);
        total_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'b0;
        end while (!rvalid);
        rv = rdata;
        rready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic t_reset();
        rd(TC);
        chk("timer ctrl", rv, 32'h0000_0000);
        rd(CN);
        chk("count", rv, 32'h0000_0000);
        rd(8'h20);
        chk("bad resp", {30'h0, rresp}, {30'h0, tgr_pkg::AXI_SLVERR});
        chk("bad data", rv, 32'h0000_0000);
    endtask

    task automatic t_wdog();
        wr(tgr_pkg::WATCHDOG_CONFIG_OFS, 32'h0000_000E);
        wr(GC, 32'h0000_00A3);
        repeat (2) @(posedge clk);
        chk("wdog osc", wdog.osc_on, 1'b1);
        chk("wdog rate", wdog.prescaler_rate, 3'h6);
        chk("wdog psa", wdog.prescaler_assign, 1'b1);
        chk("wdog reset", wdog.reset_en, 1'b0);
        chk("wdog wake", wdog.wake_en, 1'b0);
        wr(GC, 32'h0000_0003);
        repeat (2) @(posedge clk);
        chk("wdog idle", wdog.osc_on, 1'b0);
    endtask

    task automatic t_level();
        wr(GC, 32'h0000_0040);
        wr(FL, 32'h0000_0000);
        gate_lvl <= 1'b1;
        repeat (4) @(posedge clk);
        rd(GC);
        chk("level high", rv[2], 1'b1);
        gate_lvl <= 1'b0;
        repeat (4) @(posedge clk);
        rd(FL);
        chk("gate flag", rv[7], 1'b1);
        rd(GC);
        chk("level low", rv[2], 1'b0);
        wr(GC, 32'h0000_0060);
        gate_lvl <= 1'b1;
        repeat (4) @(posedge clk);
        gate_lvl <= 1'b0;
        repeat (4) @(posedge clk);
        rd(GC);
        chk("toggle level", rv[2], 1'b1);
    endtask

    task automatic t_pulse();
        wr(GC, 32'h0000_00D0);
        wr(GC, 32'h0000_00D8);
        rd(GC);
        chk("armed", rv[3], 1'b1);
        gate_lvl <= 1'b1;
        repeat (4) @(posedge clk);
        gate_lvl <= 1'b0;
        repeat (4) @(posedge clk);
        rd(GC);
        chk("armed done", rv[3], 1'b0);
        wr(GC, 32'h0000_00D8);
        wr(GC, 32'h0000_00C8);
        rd(GC);
        chk("armed off", rv[3], 1'b0);
    endtask

    task automatic t_roll();
        wr(GC, 32'h0000_00C0);
        wr(CN, 32'h0000_0000);
        wr(FL, 32'h0000_0000);
        wr(tgr_pkg::IRQ_CONTROL_OFS, 32'h0000_0040);
        wr(tgr_pkg::PERIPHERAL_ENABLE_OFS, 32'h0000_0001);
        wr(CN, 32'h0000_FFFE);
        wr(TC, 32'h0000_0001);
        clk_run <= 1'b1;
        repeat (40) @(posedge clk);
        rd(CN);
        chk("gated hold", rv, 32'h0000_FFFE);
        gate_lvl <= 1'b1;
        repeat (40) @(posedge clk);
        clk_run <= 1'b0;
        rd(CN);
        chk("wrapped", rv < 32'h0000_0010, 1'b1);
        rd(FL);
        chk("rollover", rv[0], 1'b1);
        chk("irq masked", irq, 1'b0);
        wr(tgr_pkg::IRQ_CONTROL_OFS, 32'h0000_00C0);
        repeat (2) @(posedge clk);
        chk("irq on", irq, 1'b1);
        wr(TC, 32'h0000_0000);
        repeat (2) @(posedge clk);
        chk("irq stopped", irq, 1'b0);
        rd(FL);
        chk("flag kept", rv[0], 1'b1);
        wr(FL, 32'h0000_0080);
        rd(FL);
        chk("flag cleared", rv[0], 1'b0);
    endtask

    task automatic t_ccu();
        int n = 0;
        wr(TC, 32'h0000_0080);
        wr(CN, 32'h0000_1234);
        cap_ev <= 1'b1;
        @(posedge clk);
        cap_ev <= 1'b0;
        rd(tgr_pkg::CAPTURE_COMPARE_OFS);
        chk("capture", rv, 32'h0000_1234);
        wr(tgr_pkg::CAPTURE_COMPARE_OFS, 32'h0000_0003);
        wr(CN, 32'h0000_0000);
        wr(TC, 32'h0000_0101);
        clk_run <= 1'b1;
        repeat (40)
        begin
            @(posedge clk);
            n += cmp_ev;
        end
        clk_run <= 1'b0;
        chk("compare hits", n, 1);
    endtask

    task automatic t_sleep();
        int n = 0;
        wr(CN, 32'h0000_FFFC);
        wr(TC, 32'h0000_0001);
        sleeping <= 1'b1;
        clk_run <= 1'b1;
        repeat (40) @(posedge clk);
        rd(CN);
        chk("sleep hold", rv, 32'h0000_FFFC);
        wr(TC, 32'h0000_0005);
        repeat (60)
        begin
            @(posedge clk);
            n += wake;
        end
        clk_run <= 1'b0;
        sleeping <= 1'b0;
        chk("wake count", n, 1);
        chk("wake vector", wake_vector, tgr_pkg::IRQ_VECTOR);
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_reset();
        t_wdog();
        t_level();
        t_pulse();
        t_roll();
        t_ccu();
        t_sleep();
        final_report();
    end
endmodule // tgr_timer_gate_tb
